// File: logic/tknb_pkg.sv
// Constants, modes and carrier types of the touch key notify bit updater
package tknb_pkg;
   // Register byte offsets on the APB slave
   localparam logic [7:0]  ADDR_CTRL      = 8'h00;
   localparam logic [7:0]  ADDR_KEY       = 8'h04;
   localparam logic [7:0]  ADDR_STAT      = 8'h08;
   localparam logic [7:0]  ADDR_MASK      = 8'h0C;
   localparam logic [7:0]  ADDR_STATE     = 8'h10;
   localparam logic [7:0]  ADDR_XLAT      = 8'h14;
   // Control register fields
   localparam int          CTRL_OP_LSB    = 0;
   localparam int          CTRL_NEWVER    = 2;
   localparam int          CTRL_AREA_LSB  = 3;
   localparam int          CTRL_LINK_LSB  = 5;
   localparam int          CTRL_W         = 7;
   // Key address register fields: word number, then bit index 0..15
   localparam int          KEY_WORD_LSB   = 0;
   localparam int          KEY_BIT_LSB    = 16;
   localparam int          KEY_W          = 20;
   // Event bits, shared by status and mask
   localparam int          EV_DONE        = 0;
   localparam int          EV_XLAT        = 1;
   localparam int          EV_REL         = 2;
   localparam int          EV_W           = 3;
   // Reset values
   localparam logic [6:0]  CTRL_RST       = 7'h00;
   localparam logic [19:0] KEY_RST        = 20'h0_0000;
   localparam logic [2:0]  MASK_RST       = 3'h0;
   // Relay word window that is moved into the core input-output area
   localparam logic [15:0] RELAY_LAST     = 16'd199;
   localparam logic [15:0] CORE_IO_BASE   = 16'd1000;
   localparam logic [15:0] WORD_ALL       = 16'hFFFF;

   typedef enum logic [1:0] {
      OP_MOMENTARY = 2'd0,
      OP_TOGGLE    = 2'd1,
      OP_FORCE_ON  = 2'd2,
      OP_FORCE_OFF = 2'd3
   } tknb_op_e;

   typedef enum logic [1:0] {
      AREA_DATA_MEMORY = 2'd0,
      AREA_LINK_RELAY  = 2'd1,
      AREA_CORE_IO     = 2'd2,
      AREA_OTHER       = 2'd3
   } tknb_area_e;

   typedef enum logic [1:0] {
      LINK_SERIAL_HOST = 2'd0,
      LINK_TERMINAL    = 2'd1,
      LINK_DIRECT      = 2'd2,
      LINK_SPARE       = 2'd3
   } tknb_link_e;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_BUSY = 2'b10
   } tknb_fsm_e;

   // Write request towards host memory
   typedef struct packed {
      logic        req;
      logic        word_mode;
      tknb_area_e  area;
      logic [15:0] addr;
      logic [3:0]  bit_idx;
      logic [15:0] wdata;
      logic [15:0] wmask;
   } tknb_mem_s;

   // APB request from the master
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } tknb_apb_req_s;

   // APB answer to the master
   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } tknb_apb_rsp_s;
endpackage

// File: logic/tknb_top.sv
// Touch key notify bit updater with APB registers and host memory port
`timescale 1ns/1ps
module tknb_top
   import tknb_pkg::*;
(
   input  wire logic                    clk,
   input  wire logic                    rst_b,
   input  wire tknb_pkg::tknb_apb_req_s apb_i,
   output      tknb_pkg::tknb_apb_rsp_s apb_o,
   input  wire logic                    key_pressed,
   input  wire logic                    screen_show,
   input  wire logic [15:0]             screen_word,
   output      tknb_pkg::tknb_mem_s     mem_o,
   input  wire logic                    mem_ack,
   output      logic                    irq
);
   import tknb_pkg::*;

   typedef struct packed {
      tknb_fsm_e     fsm;
      logic [6:0]    ctrl;
      logic [19:0]   keycfg;
      logic [2:0]    stat;
      logic [2:0]    mask;
      logic          word_mode;
      tknb_op_e      op_lat;
      logic [15:0]   shadow;
      logic          reported;
      logic          hold_rel;
      logic          press_pend;
      logic          key_d;
      tknb_apb_rsp_s apb;
      logic          irq;
      tknb_mem_s     mem;
   } tknb_state_s;

   tknb_state_s st_r;
   tknb_state_s st_nxt;
   logic [1:0]  rst_sync_r;
   logic        rst_n_int;

   ////////////////////////////////////////////////////////////////////////
   // One-hot mask of a bit index within a host word
   function automatic logic [15:0] bit_onehot(input logic [3:0] idx);
      bit_onehot = 16'h0001 << idx;
   endfunction

   // Relay words in the low window land in the core area; others pass
   function automatic logic [17:0] xlat(input tknb_area_e  area,
                                        input logic [15:0] word);
      if (area == AREA_LINK_RELAY && word <= RELAY_LAST) begin
         xlat = {AREA_CORE_IO, 16'(word + CORE_IO_BASE)};
      end else begin
         xlat = {area, word};
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_sync_r <= 2'b00;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n_int = rst_sync_r[1];

   ////////////////////////////////////////////////////////////////////////
   // Decoded views of the configuration
   tknb_area_e  cfg_area;
   tknb_link_e  cfg_link;
   tknb_op_e    cfg_op;
   logic [15:0] cfg_word;
   logic [3:0]  cfg_bit;
   logic        cfg_word_mode;
   logic        press_edge;
   logic        want;
   logic        cur_bit;
   logic        new_bit;
   logic [17:0] xaddr;
   logic        issue;
   logic        setup;
   logic        access;
   logic [2:0]  ev_set;
   logic [2:0]  ev_clr;

   always_comb begin
      cfg_area      = tknb_area_e'(st_r.ctrl[CTRL_AREA_LSB +: 2]);
      cfg_link      = tknb_link_e'(st_r.ctrl[CTRL_LINK_LSB +: 2]);
      cfg_word      = st_r.keycfg[KEY_WORD_LSB +: 16];
      cfg_bit       = st_r.keycfg[KEY_BIT_LSB +: 4];
      // Older version only knows momentary keys
      cfg_op        = st_r.ctrl[CTRL_NEWVER]
                      ? tknb_op_e'(st_r.ctrl[CTRL_OP_LSB +: 2])
                      : OP_MOMENTARY;
      // Word units on serial host, or terminal link into data memory
      cfg_word_mode = (cfg_link == LINK_SERIAL_HOST)
                      || (cfg_link == LINK_TERMINAL
                          && cfg_area == AREA_DATA_MEMORY);
      press_edge    = key_pressed && !st_r.key_d;
      want          = key_pressed && !st_r.hold_rel;
      cur_bit       = st_r.shadow[cfg_bit];
      xaddr         = xlat(cfg_area, cfg_word);
      setup         = apb_i.psel && !apb_i.penable;
      access        = apb_i.psel && apb_i.penable && st_r.apb.pready;
   end

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic: key tracking, host write sequencer, registers
   always_comb begin
      st_nxt  = st_r;
      issue   = 1'b0;
      new_bit = 1'b0;
      ev_set  = '0;
      ev_clr  = '0;
      st_nxt.key_d = key_pressed;

      // Press edges of latching types are kept until served or until a new screen clears them
      if (st_r.op_lat != OP_MOMENTARY && press_edge) begin
         st_nxt.press_pend = 1'b1;
      end
      if (!key_pressed) begin
         st_nxt.hold_rel = 1'b0;
      end

      // Momentary compares levels, so a burst while busy folds into at most one write
      case (st_r.fsm)
         ST_IDLE: begin
            if (st_r.op_lat == OP_MOMENTARY && want != st_r.reported) begin
               issue           = 1'b1;
               new_bit         = want;
               st_nxt.reported = want;
            end else if (st_r.op_lat != OP_MOMENTARY && st_r.press_pend) begin
               issue = 1'b1;
               case (st_r.op_lat)
                  OP_TOGGLE:   new_bit = !cur_bit;
                  OP_FORCE_ON: new_bit = 1'b1;
                  default:     new_bit = 1'b0;
               endcase
               st_nxt.shadow[cfg_bit] = new_bit;
               // A press in this very cycle stays pending
               st_nxt.press_pend = press_edge;
            end
            if (issue) begin
               st_nxt.fsm           = ST_BUSY;
               st_nxt.mem.req       = 1'b1;
               st_nxt.mem.word_mode = st_r.word_mode;
               st_nxt.mem.area      = tknb_area_e'(xaddr[17:16]);
               st_nxt.mem.addr      = xaddr[15:0];
               st_nxt.mem.bit_idx   = cfg_bit;
               ev_set[EV_XLAT]      = (xaddr[17:16] != 2'(cfg_area));
               if (!st_r.word_mode) begin
                  // Only the allocated bit is enabled
                  st_nxt.mem.wmask = bit_onehot(cfg_bit);
                  st_nxt.mem.wdata = new_bit ? bit_onehot(cfg_bit) : '0;
               end else if (st_r.op_lat == OP_MOMENTARY) begin
                  // Whole word: neighbours are cleared
                  st_nxt.mem.wmask = WORD_ALL;
                  st_nxt.mem.wdata = new_bit ? bit_onehot(cfg_bit) : '0;
               end else begin
                  // Captured copy overrides later host changes
                  st_nxt.mem.wmask = WORD_ALL;
                  st_nxt.mem.wdata = st_nxt.shadow;
               end
            end
         end
         ST_BUSY: begin
            // Request held unchanged until the host memory takes it
            if (mem_ack) begin
               st_nxt.mem.req  = 1'b0;
               st_nxt.fsm      = ST_IDLE;
               ev_set[EV_DONE] = 1'b1;
            end
         end
         default: begin
            // Unreachable codes fall back to idle with the request dropped
            st_nxt.fsm     = ST_IDLE;
            st_nxt.mem.req = 1'b0;
         end
      endcase

      // New screen: latch granularity, type and the word copy
      if (screen_show) begin
         st_nxt.word_mode  = cfg_word_mode;
         st_nxt.op_lat     = cfg_op;
         st_nxt.shadow     = screen_word;
         st_nxt.press_pend = 1'b0;
         if (key_pressed) begin
            // Key vanished with the old screen; report it released
            st_nxt.hold_rel = 1'b1;
            ev_set[EV_REL]  = (st_r.op_lat == OP_MOMENTARY)
                              && st_r.reported;
         end
      end

      // APB slave: zero wait states, answer registered at setup
      st_nxt.apb.pready  = setup;
      st_nxt.apb.pslverr = 1'b0;
      st_nxt.apb.prdata  = '0;
      if (setup) begin
         if (apb_i.paddr == ADDR_CTRL) begin
            st_nxt.apb.prdata = {25'h000_0000, st_r.ctrl};
         end else if (apb_i.paddr == ADDR_KEY) begin
            st_nxt.apb.prdata = {12'h000, st_r.keycfg};
         end else if (apb_i.paddr == ADDR_STAT) begin
            st_nxt.apb.prdata = {29'h0000_0000, st_r.stat};
         end else if (apb_i.paddr == ADDR_MASK) begin
            st_nxt.apb.prdata = {29'h0000_0000, st_r.mask};
         end else if (apb_i.paddr == ADDR_STATE) begin
            st_nxt.apb.prdata = {st_r.shadow, 8'h00, st_r.op_lat,
                                 st_r.press_pend, st_r.hold_rel,
                                 st_r.reported, st_r.word_mode,
                                 st_r.fsm == ST_BUSY, st_r.mem.req};
         end else if (apb_i.paddr == ADDR_XLAT) begin
            st_nxt.apb.prdata = {14'h0000, xaddr};
         end else begin
            st_nxt.apb.pslverr = 1'b1;  // Unmapped address
         end
      end
      // Writes land only at the pready edge of the access phase
      if (access && apb_i.pwrite) begin
         if (apb_i.paddr == ADDR_CTRL) begin
            st_nxt.ctrl = apb_i.pwdata[CTRL_W-1:0];
         end else if (apb_i.paddr == ADDR_KEY) begin
            st_nxt.keycfg = apb_i.pwdata[KEY_W-1:0];
         end else if (apb_i.paddr == ADDR_STAT) begin
            ev_clr = apb_i.pwdata[EV_W-1:0];
         end else if (apb_i.paddr == ADDR_MASK) begin
            st_nxt.mask = apb_i.pwdata[EV_W-1:0];
         end
      end

      // Sticky events: a set in the clear cycle survives
      st_nxt.stat = (st_r.stat & ~ev_clr) | ev_set;
      st_nxt.irq  = |(st_nxt.stat & st_nxt.mask);
   end

   ////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clk or negedge rst_n_int) begin
      if (!rst_n_int) begin
         st_r        <= '0;
         st_r.fsm    <= ST_IDLE;
         st_r.ctrl   <= CTRL_RST;
         st_r.keycfg <= KEY_RST;
         st_r.mask   <= MASK_RST;
         st_r.op_lat <= OP_MOMENTARY;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign apb_o = st_r.apb;
   assign mem_o = st_r.mem;
   assign irq   = st_r.irq;

   ////////////////////////////////////////////////////////////////////////
   // Checks on the sequencer and the written words
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n_int);

   a_req_held: assert property (mem_o.req && !mem_ack |=>
      mem_o.req && $stable(mem_o.wdata) && $stable(mem_o.addr))
      else $error("host write request dropped or changed before ack");
   a_mom_follow: assert property (st_r.op_lat == OP_MOMENTARY
      && !st_r.hold_rel && key_pressed && !st_r.reported
      && st_r.fsm == ST_IDLE |=> mem_o.req && mem_o.wdata[mem_o.bit_idx])
      else $error("momentary press not written as one");
   a_toggle_inv: assert property (issue && st_r.op_lat == OP_TOGGLE
      |=> mem_o.wdata[mem_o.bit_idx] != $past(cur_bit))
      else $error("toggle did not invert the notify bit");
   a_force_on: assert property (issue && st_r.op_lat == OP_FORCE_ON
      |=> mem_o.wdata[mem_o.bit_idx] && st_r.shadow[mem_o.bit_idx])
      else $error("force-on did not write one");
   a_force_off: assert property (issue && st_r.op_lat == OP_FORCE_OFF
      |=> !mem_o.wdata[mem_o.bit_idx])
      else $error("force-off did not write zero");
   a_word_clear: assert property (issue && st_r.word_mode
      && st_r.op_lat == OP_MOMENTARY |=> mem_o.wmask == WORD_ALL
      && (mem_o.wdata & ~bit_onehot(mem_o.bit_idx)) == 16'h0000)
      else $error("word momentary left other bits set");
   a_word_copy: assert property (issue && st_r.word_mode
      && st_r.op_lat != OP_MOMENTARY |=> mem_o.wmask == WORD_ALL
      && ((mem_o.wdata ^ $past(st_r.shadow))
          & ~bit_onehot(mem_o.bit_idx)) == 16'h0000)
      else $error("word write not built from captured copy");
   a_bit_only: assert property (mem_o.req && !mem_o.word_mode
      |-> mem_o.wmask == bit_onehot(mem_o.bit_idx))
      else $error("bit mode touched other bits");
   // Idle and still momentary: the release write stands two edges later
   a_screen_rel: assert property (screen_show && key_pressed
      && st_r.op_lat == OP_MOMENTARY && cfg_op == OP_MOMENTARY
      && st_r.reported && st_r.fsm == ST_IDLE
      |-> ##2 (mem_o.req && !mem_o.wdata[mem_o.bit_idx]))
      else $error("screen change did not release momentary key");
   a_relay_move: assert property (issue && cfg_area == AREA_LINK_RELAY
      && cfg_word <= RELAY_LAST |=> mem_o.area == AREA_CORE_IO
      && mem_o.addr == $past(cfg_word) + CORE_IO_BASE)
      else $error("relay word not moved to core area");
   a_old_fixed: assert property (screen_show && !st_r.ctrl[CTRL_NEWVER]
      |=> st_r.op_lat == OP_MOMENTARY)
      else $error("older version allowed a latching type");
   a_gran_latch: assert property (screen_show
      |=> st_r.word_mode == $past(cfg_word_mode))
      else $error("granularity not latched at display");
   // Ack is taken once, so the request must fall at the next edge
   a_ack_drop: assert property (mem_o.req && mem_ack
      |=> !mem_o.req)
      else $error("host write request held after ack");
   // Words outside the relay window keep their area and number
   a_relay_keep: assert property (issue
      && !(cfg_area == AREA_LINK_RELAY && cfg_word <= RELAY_LAST)
      |=> mem_o.area == $past(cfg_area) && mem_o.addr == $past(cfg_word))
      else $error("word outside relay window was moved");
   // The allocated bit index travels unchanged with every request
   a_bit_index: assert property (issue
      |=> mem_o.bit_idx == $past(cfg_bit))
      else $error("request carries the wrong bit index");
   // Word writes enable the whole word in both word-mode cases
   a_word_mask: assert property (mem_o.req && mem_o.word_mode
      |-> mem_o.wmask == WORD_ALL)
      else $error("word mode write did not enable the whole word");

   c_word_mom: cover property (issue && st_r.word_mode
      && st_r.op_lat == OP_MOMENTARY);
   c_bit_toggle: cover property (issue && !st_r.word_mode
      && st_r.op_lat == OP_TOGGLE);
   c_screen_rel: cover property (ev_set[EV_REL]);
   c_relay_move: cover property (issue && ev_set[EV_XLAT]);
   c_word_force: cover property (issue && st_r.word_mode
      && st_r.op_lat == OP_FORCE_ON);
endmodule

// File: sim/tknb_host_model.sv
// Host controller memory model that takes notify bit writes
`timescale 1ns/1ps
module tknb_host_model
   import tknb_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                rst_b,
   input  wire tknb_pkg::tknb_mem_s mem_i,
   input  wire logic [31:0]         delay,
   output      logic                mem_ack
);
   logic [15:0] mem [logic [15:0]];
   logic [1:0]  last_area;
   int          n_writes = 0;
   int          wait_cnt;
   ///////////////////////////////////////////////////////////////////////
   // Ack after a set wait; only enabled bits of the word are merged,
   // so a bit-mode write cannot disturb its neighbours here by accident
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mem_ack  <= 1'b0;
         wait_cnt <= 0;
      end else if (mem_ack && mem_i.req) begin
         mem_ack   <= 1'b0;
         wait_cnt  <= 0;
         mem[mem_i.addr] = (mem[mem_i.addr] & ~mem_i.wmask)
                         | (mem_i.wdata & mem_i.wmask);
         last_area <= mem_i.area;
         n_writes  = n_writes + 1;
      end else if (mem_i.req && wait_cnt >= delay) begin
         mem_ack <= 1'b1;
      end else if (mem_i.req) begin
         wait_cnt <= wait_cnt + 1;
      end
   end
endmodule

// File: sim/tknb_top_test.sv
// Self-checking bench of the touch key notify bit updater
`timescale 1ns/1ps
module tknb_top_test;
   import tknb_pkg::*;
   typedef struct packed {
      logic [6:0]  ctrl;
      logic [19:0] key;
      logic [15:0] maddr;
      logic [1:0]  marea;
      logic [15:0] init;
      logic [15:0] scr;
      logic [15:0] w_on;
      logic [15:0] w_off;
      logic [15:0] w_on2;
   } tknb_row_s;
   logic          clk;
   logic          rst_b;
   tknb_apb_req_s apb_i;
   tknb_apb_rsp_s apb_o;
   logic          key_pressed;
   logic          screen_show;
   logic [15:0]   screen_word;
   tknb_mem_s     mem_o;
   logic          mem_ack;
   logic          irq;
   int            host_delay;
   int            n_mismatch;
   int            samples_checked;
   int            n0;
   logic [31:0]   rd;
   logic          err;
   // Word mode rows never mix momentary and latching keys in one word
   tknb_row_s     rows [9] = '{
      '{7'h04, 20'h3_0005, 16'h0005, 2'd0, 16'hABCD, 16'hABCD,
        16'h0008, 16'h0000, 16'h0008},
      '{7'h44, 20'hF_0006, 16'h0006, 2'd0, 16'h1234, 16'h1234,
        16'h9234, 16'h1234, 16'h9234},
      '{7'h25, 20'h2_0007, 16'h0007, 2'd0, 16'h00F0, 16'h5A00,
        16'h5A04, 16'h5A04, 16'h5A00},
      '{7'h3D, 20'h1_0008, 16'h0008, 2'd3, 16'h00F0, 16'h00F0,
        16'h00F2, 16'h00F2, 16'h00F0},
      '{7'h16, 20'h0_0009, 16'h0009, 2'd2, 16'h0F00, 16'h8001,
        16'h8001, 16'h8001, 16'h8001},
      '{7'h57, 20'h4_000A, 16'h000A, 2'd2, 16'hFFFF, 16'hFFFF,
        16'hFFEF, 16'hFFEF, 16'hFFEF},
      '{7'h41, 20'h7_000B, 16'h000B, 2'd0, 16'h0000, 16'h0000,
        16'h0080, 16'h0000, 16'h0080},
      '{7'h4C, 20'h0_00C7, 16'h04AF, 2'd2, 16'h0000, 16'h0000,
        16'h0001, 16'h0000, 16'h0001},
      '{7'h4C, 20'h0_00C8, 16'h00C8, 2'd1, 16'h5500, 16'h5500,
        16'h5501, 16'h5500, 16'h5501}};

   tknb_top u_tknb_top (.clk(clk), .rst_b(rst_b), .apb_i(apb_i),
      .apb_o(apb_o), .key_pressed(key_pressed), .screen_show(screen_show),
      .screen_word(screen_word), .mem_o(mem_o), .mem_ack(mem_ack),
      .irq(irq));
   tknb_host_model u_tknb_host_model (.clk(clk), .rst_b(rst_b),
      .mem_i(mem_o), .delay(host_delay), .mem_ack(mem_ack));
   ///////////////////////////////////////////////////////////////////////
   // Helpers for comparing, ending the run and reading the host memory
   function automatic logic [31:0] hw(input logic [15:0] a);
      return 32'(u_tknb_host_model.mem[a]);
   endfunction
   function automatic int nw();
      return u_tknb_host_model.n_writes;
   endfunction
   task automatic close_out();
      $display("Compared %0d, mismatched %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One APB transfer; pready, read data and error are taken at one edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int i;
      @(posedge clk);
      apb_i <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk);
      apb_i.penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (apb_o.pready === 1'b1) break;
      end
      if (i == 20) begin
         n_mismatch++;
         close_out();
      end
      rd = apb_o.prdata;
      err = apb_o.pslverr;
      apb_i <= '{1'b0, 1'b0, w, a, d};
   endtask
   task automatic key(input logic v);
      @(posedge clk);
      key_pressed <= v;
   endtask
   task automatic show(input logic [15:0] w);
      @(posedge clk);
      screen_show <= 1'b1;
      screen_word <= w;
      @(posedge clk);
      screen_show <= 1'b0;
   endtask
   // Bounded wait until the host model has taken n writes in all
   task automatic wait_wr(input int n);
      int i;
      for (i = 0; i < 200 && nw() < n; i++) begin
         @(posedge clk);
      end
      if (i == 200) begin
         n_mismatch++;
         close_out();
      end
      repeat (3) @(posedge clk);
   endtask
   ///////////////////////////////////////////////////////////////////////
   // Clock of 20 ns
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Main sequence: table rows first, then the awkward cases
   initial begin
      tknb_row_s r;
      logic      mom;
      rst_b = 1'b0;
      apb_i = '0;
      key_pressed = 1'b0;
      screen_show = 1'b0;
      screen_word = 16'h0000;
      host_delay = 0;
      n_mismatch = 0;
      samples_checked = 0;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      foreach (rows[i]) begin
         r = rows[i];
         host_delay <= (i % 3) * 4;
         mom = r.ctrl[1:0] == 2'd0 || !r.ctrl[2];
         apb(1'b1, ADDR_CTRL, 32'(r.ctrl));
         apb(1'b1, ADDR_KEY, 32'(r.key));
         u_tknb_host_model.mem[r.maddr] = r.init;
         show(r.scr);
         n0 = nw();
         key(1'b1);
         wait_wr(n0 + 1);
         chk(hw(r.maddr), 32'(r.w_on));
         key(1'b0);
         if (mom) wait_wr(n0 + 2);
         else repeat (10) @(posedge clk);
         chk(hw(r.maddr), 32'(r.w_off));
         n0 = nw();
         key(1'b1);
         wait_wr(n0 + 1);
         chk(hw(r.maddr), 32'(r.w_on2));
         chk(32'(u_tknb_host_model.last_area), 32'(r.marea));
         key(1'b0);
         if (mom) wait_wr(n0 + 2);
      end
      // Screen change under a held momentary key in word mode
      apb(1'b1, ADDR_CTRL, 32'h0000_0004);
      apb(1'b1, ADDR_KEY, 32'h0003_0005);
      show(16'h0000);
      n0 = nw();
      key(1'b1);
      wait_wr(n0 + 1);
      u_tknb_host_model.mem[16'h0005] = 16'h00F8;
      show(16'h00F8);
      wait_wr(n0 + 2);
      chk(hw(16'h0005), 32'h0000_0000);
      repeat (10) @(posedge clk);
      chk(32'(nw()), 32'(n0 + 2));
      key(1'b0);
      key(1'b1);
      wait_wr(n0 + 3);
      chk(hw(16'h0005), 32'h0000_0008);
      key(1'b0);
      wait_wr(n0 + 4);
      // Presses during a slow write collapse into one pending press
      host_delay <= 30;
      apb(1'b1, ADDR_CTRL, 32'h0000_003D);
      apb(1'b1, ADDR_KEY, 32'h0001_0008);
      u_tknb_host_model.mem[16'h0008] = 16'h00F0;
      show(16'h00F0);
      n0 = nw();
      repeat (3) begin
         key(1'b1);
         key(1'b0);
      end
      wait_wr(n0 + 2);
      repeat (40) @(posedge clk);
      chk(32'(nw()), 32'(n0 + 2));
      chk(hw(16'h0008), 32'h0000_00F0);
      // Interrupt raised, masked and cleared
      host_delay <= 2;
      apb(1'b1, ADDR_STAT, 32'h0000_0007);
      apb(1'b0, ADDR_STAT, 32'h0);
      chk(rd, 32'h0000_0000);
      apb(1'b1, ADDR_MASK, 32'h0000_0001);
      key(1'b1);
      wait_wr(n0 + 3);
      key(1'b0);
      chk(32'(irq), 32'h1);
      apb(1'b1, ADDR_MASK, 32'h0);
      repeat (2) @(posedge clk);
      chk(32'(irq), 32'h0);
      apb(1'b1, ADDR_MASK, 32'h0000_0001);
      apb(1'b1, ADDR_STAT, 32'h0000_0001);
      repeat (2) @(posedge clk);
      chk(32'(irq), 32'h0);
      // Latched type toggle, copy with the bit set, sequencer idle
      apb(1'b0, ADDR_STATE, 32'h0);
      chk(rd, 32'h00F2_0040);
      // Translation view, read-only write and an unmapped offset
      apb(1'b1, ADDR_CTRL, 32'h0000_004C);
      apb(1'b1, ADDR_KEY, 32'h0000_00C7);
      apb(1'b1, ADDR_XLAT, 32'hFFFF_FFFF);
      apb(1'b0, ADDR_XLAT, 32'h0);
      chk(rd, 32'h0002_04AF);
      apb(1'b0, 8'h18, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0000_0000);
      // Second reset in mid-run, then reset values
      rst_b <= 1'b0;
      repeat (10) @(posedge clk);
      chk({29'h0, mem_o.req, irq, apb_o.pready}, 32'h0);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk(rd, 32'(CTRL_RST));
      apb(1'b0, ADDR_KEY, 32'h0);
      chk(rd, 32'(KEY_RST));
      apb(1'b0, ADDR_MASK, 32'h0);
      chk(rd, 32'(MASK_RST));
      close_out();
   end
endmodule
